//--- ssep_byte_eng.v
// Purpose: Two-wire bit engine: start, stop, byte write, byte read
// Assumes: One tick per quarter bit; open-drain pins, enable high pulls low
// Notes: No clock stretching by the slave is honoured
`include "ssep_map.vh"

module ssep_byte_eng (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Quarter-bit enable
   input wire tick,
   // Operation request
   input wire op_valid,
   input wire [1:0] op_kind,
   input wire [7:0] op_byte,
   input wire op_nak,
   // Operation result
   output reg op_done,
   output reg [7:0] rx_byte,
   output reg ack_in,
   // Pins
   input wire sda_s,
   output reg scl_oe,
   output reg sda_oe
);

   reg busy_q;
   reg [1:0] kind_q;
   reg [1:0] qtr_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg nak_q;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         kind_q <= 2'h0;
         qtr_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         nak_q <= 1'b0;
         op_done <= 1'b0;
         rx_byte <= 8'h00;
         ack_in <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         op_done <= 1'b0;
         if (!busy_q) begin
            if (op_valid) begin
               busy_q <= 1'b1;
               kind_q <= op_kind;
               sh_q <= op_byte;
               nak_q <= op_nak;
               qtr_q <= 2'h0;
               bit_q <= 4'h0;
            end
         end else if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            case (kind_q)
               `SSEP_OP_START: begin
                  // Works from idle bus and as a repeated start
                  case (qtr_q)
                     2'h0: sda_oe <= 1'b0;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b1;
                     default: begin
                        scl_oe <= 1'b1;
                        busy_q <= 1'b0;
                        op_done <= 1'b1;
                     end
                  endcase
               end
               `SSEP_OP_STOP: begin
                  case (qtr_q)
                     2'h0: sda_oe <= 1'b1;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     default: begin
                        busy_q <= 1'b0;
                        op_done <= 1'b1;
                     end
                  endcase
               end
               default: begin
                  case (qtr_q)
                     2'h0: begin
                        if (bit_q == 4'h8) begin
                           sda_oe <= (kind_q == `SSEP_OP_READ) ? ~nak_q : 1'b0;
                        end else begin
                           sda_oe <= (kind_q == `SSEP_OP_WRITE) ? ~sh_q[7] : 1'b0;
                        end
                     end
                     2'h1: scl_oe <= 1'b0;
                     2'h2: begin
                        if (bit_q == 4'h8) begin
                           ack_in <= sda_s;
                        end else begin
                           sh_q <= {sh_q[6:0], sda_s};
                        end
                     end
                     default: begin
                        scl_oe <= 1'b1;
                        if (bit_q == 4'h8) begin
                           busy_q <= 1'b0;
                           op_done <= 1'b1;
                           rx_byte <= sh_q;
                        end else begin
                           bit_q <= bit_q + 4'h1;
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end

endmodule // ssep_byte_eng

//--- ssep_eeprom_model.sv
// Purpose: Behavioural two-wire serial EEPROM
// Assumes: Wires resolved by the bench with pull-ups
// Notes: No write cycle time, so a read may follow a write at once
module ssep_eeprom_model #(
   parameter logic [6:0] DEV = 7'h50
) (
   // Wires
   input wire scl,
   input wire sda,
   // Pull data line low
   output logic pull
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255];
   logic [7:0] ptr;
   logic [7:0] b;
   logic m;
   bit c;

   task automatic get_byte(output logic [7:0] v, output bit cnd);
      cnd = 0;
      for (int i = 0; i < 8; i++) begin
         @(posedge scl);
         v = {v[6:0], sda};
         @(negedge scl or sda);
         // Data moving while clock high is a start or stop
         if (scl === 1'b1) begin
            cnd = 1;
            return;
         end
      end
   endtask

   task automatic ack();
      pull = 1'b1;
      @(posedge scl);
      @(negedge scl);
      pull = 1'b0;
   endtask

   initial begin
      pull = 1'b0;
      for (int i = 0; i < 256; i++)
         mem[i] = i[7:0] ^ 8'h5a;
      forever begin
         @(negedge sda iff scl === 1'b1);
         c = 1;
         while (c && sda === 1'b0) begin
            get_byte(b, c);
            // Other address: stay released so the master sees no acknowledge
            if (c || b[7:1] !== DEV)
               break;
            ack();
            if (b[0]) begin
               do begin
                  for (int i = 7; i >= 0; i--) begin
                     pull = !mem[ptr][i];
                     @(posedge scl);
                     @(negedge scl);
                  end
                  pull = 1'b0;
                  ptr = ptr + 8'h01;
                  @(posedge scl);
                  m = sda;
                  @(negedge scl);
               end while (m === 1'b0);
               c = 0;
            end else begin
               get_byte(ptr, c);
               if (c)
                  break;
               ack();
               forever begin
                  get_byte(b, c);
                  if (c)
                     break;
                  mem[ptr] = b;
                  ptr = ptr + 8'h01;
                  ack();
               end
            end
         end
      end
   end
endmodule // ssep_eeprom_model

//--- ssep_map.vh
// Purpose: Constants for the serial EEPROM access port
// Assumes: Local register bus with byte addresses, 100 MHz core clock
// Notes: Definitions only
`ifndef SSEP_MAP_VH
`define SSEP_MAP_VH

// Register byte offsets
`define SSEP_OFS_CMD 12'h4a0
`define SSEP_OFS_RDATA 12'h4a4
`define SSEP_OFS_STATUS 12'h4a8

// Command word fields
`define SSEP_CMD_DEV_HI 30
`define SSEP_CMD_DEV_LO 24
`define SSEP_CMD_MEM_HI 23
`define SSEP_CMD_MEM_LO 16
`define SSEP_CMD_WD_HI 15
`define SSEP_CMD_WD_LO 8
`define SSEP_CMD_TYPE 1
`define SSEP_CMD_DIR 0
`define SSEP_DEV_RESET 7'h50

// Status fields
`define SSEP_ST_DEV_NAK 7
`define SSEP_ST_MEM_NAK 6
`define SSEP_ST_DEV2_NAK 5
`define SSEP_ST_DONE 0

// Byte engine operations
`define SSEP_OP_START 2'h0
`define SSEP_OP_STOP 2'h1
`define SSEP_OP_WRITE 2'h2
`define SSEP_OP_READ 2'h3

// Timing: quarter of a 100 kHz bit period
`define SSEP_CLK_NS 10
`define SSEP_QTR_NS 2500
`define SSEP_QTR_CYC ((`SSEP_QTR_NS + `SSEP_CLK_NS - 1) / `SSEP_CLK_NS)
`define SSEP_DIV_W 9

`endif

//--- ssep_port.v
// Purpose: Register-driven two-wire master that reads and writes a serial EEPROM
// Assumes: Local register bus, single-cycle strobes, byte enables, core clock
// Notes: Command writes while a transfer runs are dropped
`include "ssep_map.vh"

module ssep_port (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Local register bus
   input wire [11:0] lb_addr,
   input wire [3:0] lb_be,
   input wire lb_wr,
   input wire lb_rd,
   input wire [31:0] lb_wdata,
   output reg [31:0] lb_rdata,
   output reg lb_rvalid,
   // Two-wire pins, open drain
   input wire sda_i,
   output reg scl_o,
   output wire scl_oe,
   output reg sda_o,
   output wire sda_oe
);

   localparam [8:0] S_IDLE = 9'h001;
   localparam [8:0] S_START = 9'h002;
   localparam [8:0] S_DEVW = 9'h004;
   localparam [8:0] S_MADR = 9'h008;
   localparam [8:0] S_WDAT = 9'h010;
   localparam [8:0] S_RSTART = 9'h020;
   localparam [8:0] S_DEVR = 9'h040;
   localparam [8:0] S_RDAT = 9'h080;
   localparam [8:0] S_STOP = 9'h100;
   // Count wraps one short of the quarter length; only the counter's own bits are kept
   localparam integer QTR_LAST_I = `SSEP_QTR_CYC - 1;
   localparam [`SSEP_DIV_W-1:0] QTR_LAST = QTR_LAST_I[`SSEP_DIV_W-1:0];

   // Command fields
   reg [6:0] dev_q;
   reg [7:0] mem_q;
   reg [7:0] wd_q;
   reg four_q;
   reg rd_dir_q;
   // Results
   reg [31:0] rdata_q;
   reg [2:0] nak_q;
   reg done_q;
   // Sequencer
   reg [8:0] st_q;
   reg op_valid_q;
   reg [1:0] cnt_q;
   reg [`SSEP_DIV_W-1:0] div_q;
   reg tick_q;
   reg sda_m_q;
   reg sda_s_q;

   wire op_done;
   wire [7:0] rx_byte;
   wire ack_in;
   wire cmd_wr;
   wire start_req;
   wire last_byte;
   reg [1:0] op_kind;
   reg [7:0] op_byte;
   reg [31:0] status_w;

   function hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // A busy port drops the whole write, so half a command never mixes into a running one
   assign cmd_wr = lb_wr && hit(lb_addr, `SSEP_OFS_CMD) && (st_q == S_IDLE);
   assign start_req = cmd_wr && lb_be[0];
   assign last_byte = !four_q || (cnt_q == 2'h3);

   // Operation and byte offered to the engine for the present phase
   always @* begin
      op_kind = `SSEP_OP_WRITE;
      op_byte = 8'h00;
      case (st_q)
         S_START: op_kind = `SSEP_OP_START;
         S_RSTART: op_kind = `SSEP_OP_START;
         S_STOP: op_kind = `SSEP_OP_STOP;
         S_DEVW: op_byte = {dev_q, 1'b0};
         S_MADR: op_byte = mem_q;
         S_WDAT: op_byte = wd_q;
         S_DEVR: op_byte = {dev_q, 1'b1};
         S_RDAT: op_kind = `SSEP_OP_READ;
         default: op_kind = `SSEP_OP_WRITE;
      endcase
   end

   // Status word built from the field positions
   always @* begin
      status_w = 32'h0000_0000;
      status_w[`SSEP_ST_DEV_NAK] = nak_q[2];
      status_w[`SSEP_ST_MEM_NAK] = nak_q[1];
      status_w[`SSEP_ST_DEV2_NAK] = nak_q[0];
      status_w[`SSEP_ST_DONE] = done_q;
   end

   // Quarter-bit enable divider
   // Tick is registered, so every pin change lands on the same quarter grid
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= {`SSEP_DIV_W{1'b0}};
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == QTR_LAST);
         div_q <= (div_q == QTR_LAST) ? {`SSEP_DIV_W{1'b0}} : div_q + 1'b1;
      end
   end

   // Data pin synchroniser
   // The wire moves with no regard to clk; logic reads only the second flop
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
      end
   end

   // Command fields; lanes written independently so narrow buses can build the word
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dev_q <= `SSEP_DEV_RESET;
         mem_q <= 8'h00;
         wd_q <= 8'h00;
         four_q <= 1'b0;
         rd_dir_q <= 1'b0;
      end else if (cmd_wr) begin
         if (lb_be[3]) begin
            dev_q <= lb_wdata[`SSEP_CMD_DEV_HI:`SSEP_CMD_DEV_LO];
         end
         if (lb_be[2]) begin
            mem_q <= lb_wdata[`SSEP_CMD_MEM_HI:`SSEP_CMD_MEM_LO];
         end
         if (lb_be[1]) begin
            wd_q <= lb_wdata[`SSEP_CMD_WD_HI:`SSEP_CMD_WD_LO];
         end
         if (lb_be[0]) begin
            four_q <= lb_wdata[`SSEP_CMD_TYPE];
            rd_dir_q <= lb_wdata[`SSEP_CMD_DIR];
         end
      end
   end

   // Transfer sequencer
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         op_valid_q <= 1'b0;
         cnt_q <= 2'h0;
         nak_q <= 3'h0;
         // Nothing is in progress after reset, so done reads high
         done_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         op_valid_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               // Old acknowledge results cleared so status tells of this transfer only
               if (start_req) begin
                  st_q <= S_START;
                  op_valid_q <= 1'b1;
                  nak_q <= 3'h0;
                  done_q <= 1'b0;
                  cnt_q <= 2'h0;
               end
            end
            S_START: begin
               if (op_done) begin
                  st_q <= S_DEVW;
                  op_valid_q <= 1'b1;
               end
            end
            S_DEVW: begin
               // A refused address skips the rest but still ends with a stop
               if (op_done) begin
                  nak_q[2] <= ack_in;
                  st_q <= ack_in ? S_STOP : S_MADR;
                  op_valid_q <= 1'b1;
               end
            end
            S_MADR: begin
               if (op_done) begin
                  nak_q[1] <= ack_in;
                  st_q <= ack_in ? S_STOP : (rd_dir_q ? S_RSTART : S_WDAT);
                  op_valid_q <= 1'b1;
               end
            end
            S_WDAT: begin
               if (op_done) begin
                  st_q <= S_STOP;
                  op_valid_q <= 1'b1;
               end
            end
            S_RSTART: begin
               if (op_done) begin
                  st_q <= S_DEVR;
                  op_valid_q <= 1'b1;
               end
            end
            S_DEVR: begin
               if (op_done) begin
                  nak_q[0] <= ack_in;
                  st_q <= ack_in ? S_STOP : S_RDAT;
                  op_valid_q <= 1'b1;
               end
            end
            S_RDAT: begin
               if (op_done) begin
                  // Byte n of the burst goes to lane n
                  case (cnt_q)
                     2'h0: rdata_q[7:0] <= rx_byte;
                     2'h1: rdata_q[15:8] <= rx_byte;
                     2'h2: rdata_q[23:16] <= rx_byte;
                     default: rdata_q[31:24] <= rx_byte;
                  endcase
                  cnt_q <= cnt_q + 2'h1;
                  st_q <= last_byte ? S_STOP : S_RDAT;
                  op_valid_q <= 1'b1;
               end
            end
            S_STOP: begin
               // Done rises only once both wires are released
               if (op_done) begin
                  st_q <= S_IDLE;
                  done_q <= 1'b1;
               end
            end
            default: begin
               st_q <= S_IDLE;
               done_q <= 1'b1;
            end
         endcase
      end
   end

   // Register read port; answer one cycle after the strobe
   // Write-only command and unmapped offsets read as zero
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lb_rdata <= 32'h0000_0000;
         lb_rvalid <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         lb_rvalid <= lb_rd;
         if (lb_rd) begin
            if (hit(lb_addr, `SSEP_OFS_RDATA)) begin
               lb_rdata <= rdata_q;
            end else if (hit(lb_addr, `SSEP_OFS_STATUS)) begin
               lb_rdata <= status_w;
            end else begin
               lb_rdata <= 32'h0000_0000;
            end
         end
      end
   end

   // Last burst byte is answered with no-acknowledge to end the read
   // One-cycle valid: the engine has just gone idle when it arrives
   ssep_byte_eng u_eng (
      .clk(clk),
      .rst_b(rst_b),
      .tick(tick_q),
      .op_valid(op_valid_q),
      .op_kind(op_kind),
      .op_byte(op_byte),
      .op_nak(last_byte),
      .op_done(op_done),
      .rx_byte(rx_byte),
      .ack_in(ack_in),
      .sda_s(sda_s_q),
      .scl_oe(scl_oe),
      .sda_oe(sda_oe)
   );

endmodule // ssep_port

//--- ssep_port_sva.sv
// Purpose: Port assertions for the serial EEPROM access port
// Assumes: Quarter bit of 250 clocks, both pins released when idle
// Notes: Bound to ssep_port at the foot
module ssep_port_chk (
   // Clock, reset
   input wire clk,
   input wire rst_b,
   // Register bus
   input wire [11:0] lb_addr,
   input wire [3:0] lb_be,
   input wire lb_wr,
   input wire lb_rd,
   input wire [31:0] lb_wdata,
   input wire [31:0] lb_rdata,
   input wire lb_rvalid,
   // Pins
   input wire sda_i,
   input wire scl_o,
   input wire scl_oe,
   input wire sda_o,
   input wire sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] idle_q;
   wire go = lb_wr && lb_addr == 12'h4a0 && lb_be[0];
   wire idle = idle_q[9];
   // Longest released spell inside a frame is 500 clocks, so 512 means no frame
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         idle_q <= 10'h000;
      else if (scl_oe || sda_oe)
         idle_q <= 10'h000;
      else if (!idle_q[9])
         idle_q <= idle_q + 10'h001;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   rd_answer_a: assert property (lb_rvalid == $past(lb_rd)) else $error("read answer mistimed");
   rdata_hold_a: assert property (!lb_rvalid |-> $stable(lb_rdata)) else $error("read data moved");
   cmd_read_zero_a: assert property (lb_rd && lb_addr != 12'h4a4 && lb_addr != 12'h4a8 |=> lb_rdata == 32'h0)
      else $error("command read not zero");
   status_spare_a: assert property (lb_rd && lb_addr == 12'h4a8 |=> lb_rdata[31:8] == 24'h0 && lb_rdata[4:1] == 4'h0)
      else $error("status spare bits set");
   busy_flag_a: assert property ((go && idle) ##1 (lb_rd && lb_addr == 12'h4a8) |=> !lb_rdata[0])
      else $error("done high after start");
   start_go_a: assert property (go && idle |-> ##[1:1000] ($rose(sda_oe) && !scl_oe))
      else $error("no start condition");
   no_start_a: assert property (lb_wr && lb_addr == 12'h4a0 && !lb_be[0] && idle |=> !sda_oe [*8])
      else $error("started without low byte");
   scl_rise_a: assert property ($rose(scl_oe) |-> $stable(sda_oe)) else $error("data moved with clock");
   scl_fall_a: assert property ($fell(scl_oe) |-> $stable(sda_oe)) else $error("data moved with clock");
   drive_low_a: assert property (!scl_o && !sda_o) else $error("pin driven high");
   cover property (go && idle);
   cover property ($rose(sda_oe) && !scl_oe);
   cover property (lb_rvalid && lb_rdata[7]);
endmodule // ssep_port_chk

bind ssep_port ssep_port_chk u_chk (.clk, .rst_b, .lb_addr, .lb_be, .lb_wr, .lb_rd, .lb_wdata, .lb_rdata,
   .lb_rvalid, .sda_i, .scl_o, .scl_oe, .sda_o, .sda_oe);

//--- test_serial_eeprom_access_port.sv
// Purpose: Self-checking bench for the serial EEPROM access port
// Assumes: Fixed 250-clock quarter bit, so frames are long
// Notes: Polls done instead of timing frames exactly
module test_serial_eeprom_access_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] lb_addr = 12'h000;
   logic [3:0] lb_be = 4'h0;
   logic lb_wr = 1'b0;
   logic lb_rd = 1'b0;
   logic [31:0] lb_wdata = 32'h0;
   logic [31:0] d;
   wire [31:0] lb_rdata;
   wire lb_rvalid, scl_o, scl_oe, sda_o, sda_oe, pull;
   wire scl = !scl_oe;
   wire sda = !(sda_oe || pull);
   int errors = 0;
   int comparisons = 0;

   always #5 clk = ~clk;

   ssep_port DUT (.clk, .rst_b, .lb_addr, .lb_be, .lb_wr, .lb_rd, .lb_wdata, .lb_rdata, .lb_rvalid,
      .sda_i(sda), .scl_o, .scl_oe, .sda_o, .sda_oe);
   ssep_eeprom_model rom (.scl, .sda, .pull);

   task automatic report_and_stop();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Strobe left high; the following read lowers it
   task automatic bus_wr(input logic [3:0] be, input logic [31:0] data);
      lb_addr = 12'h4a0;
      lb_be = be;
      lb_wdata = data;
      lb_wr = 1'b1;
      @(negedge clk);
   endtask

   task automatic bus_rd(input logic [11:0] addr);
      lb_wr = 1'b0;
      lb_addr = addr;
      lb_rd = 1'b1;
      @(negedge clk);
      // Answer stands only in the cycle after the strobe edge
      lb_rd = 1'b0;
      d = lb_rdata;
      check({31'h0, lb_rvalid}, 32'h1);
      @(negedge clk);
   endtask

   task automatic wait_done();
      int i;
      for (i = 0; i < 150; i++) begin
         repeat (500) @(negedge clk);
         bus_rd(12'h4a8);
         if (d[0] === 1'b1)
            break;
      end
      if (i == 150) begin
         check(d, 32'h1);
         report_and_stop();
      end
      repeat (600) @(negedge clk);
   endtask

   task automatic t_reset();
      bus_rd(12'h4a8);
      check(d, 32'h1);
      bus_rd(12'h4a4);
      check(d, 32'h0);
      bus_rd(12'h4a0);
      check(d, 32'h0);
      bus_rd(12'h4ac);
      check(d, 32'h0);
      $display("test reset values finished");
   endtask

   task automatic t_write();
      repeat (600) @(negedge clk);
      bus_wr(4'b0110, 32'h0040c300);
      bus_wr(4'b0001, 32'h0);
      bus_rd(12'h4a8);
      check(d, 32'h0);
      wait_done();
      check(d, 32'h1);
      check({24'h0, rom.mem[8'h40]}, 32'hc3);
      $display("test write finished");
   endtask

   task automatic t_read4();
      bus_wr(4'b1111, 32'h503fee03);
      bus_rd(12'h4a8);
      check(d, 32'h0);
      repeat (3000) @(negedge clk);
      bus_wr(4'b1111, 32'h50000000); // Dropped while busy
      bus_rd(12'h4a8);
      check(d, 32'h0);
      wait_done();
      check(d, 32'h1);
      bus_rd(12'h4a4);
      check(d, 32'h181bc365);
      check({24'h0, rom.mem[8'h00]}, 32'h5a);
      $display("test four-byte read finished");
   endtask

   task automatic t_nak();
      bus_wr(4'b1111, 32'h51000001);
      bus_rd(12'h4a8);
      check(d, 32'h0);
      wait_done();
      check(d, 32'h81);
      $display("test refused address finished");
   endtask

   initial begin
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
      t_write();
      t_read4();
      t_nak();
      report_and_stop();
   end
endmodule // test_serial_eeprom_access_port
